// ==== vet_defines.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef VET_DEFINES_SVH
`define VET_DEFINES_SVH
`define VET_OFF_MODE_SECOND 12'h000
`define VET_OFF_TIMING_CONTROL_FIRST 12'h004
`define VET_OFF_TIMING_SECOND 12'h008
`define VET_OFF_PED_ODD 12'h00c
`define VET_OFF_PED_EVEN 12'h010
`define VET_OFF_SC_FREQ 12'h014
`define VET_OFF_STATUS 12'h018
`define VET_OFF_RTC_FREQ 12'h01c
`define VET_COLOR_ENABLE_BIT 0
`define VET_BURST_ENABLE_BIT 1
`define VET_SUBCARRIER_MODE_LOW_BIT 2
`define VET_SUBCARRIER_MODE_HIGH_BIT 3
`define VET_VBI_OPEN_BIT 4
`define VET_WIDE_INPUT_BIT 5
`define VET_BLANK_IN_EN_BIT 6
`define VET_PAL_BIT 7
`define VET_SQUARE_BIT 8
`define VET_MODE_RST 9'h003
`define VET_TMODE_RST 3'h0
`define VET_TIMING2_RST 16'h0040
`define VET_PED_RST 32'h0000_0000
`define VET_SCF_RST 32'h0000_0000
`define VET_NTSC_LINE 11'd1716
`define VET_PAL_LINE 11'd1728
`define VET_NTSC_SQ_LINE 11'd1560
`define VET_PAL_SQ_LINE 11'd1888
`define VET_NTSC_FIELD 10'd263
`define VET_PAL_FIELD 10'd313
`define VET_ACT_START 11'd272
`define VET_BURST_START 11'd76
`define VET_BURST_END 11'd112
`define VET_SER_START 10'd3
`define VET_SER_END 10'd6
`define VET_EQ_END 10'd9
`define VET_VBL_END 10'd20
`define VET_PED_LINES 10'd32
`define VET_RTC_WORD 7'd67
`define VET_RTC_FREQ_BITS 7'd22
`endif

// ==== vet_pkg.sv ====
// Types shared by the video encoder timing front end.
package vet_pkg;
  typedef enum logic [2:0] {
    TM_EMB_SLAVE = 3'b000,
    TM_EMB_MASTER = 3'b001,
    TM_HF_SLAVE = 3'b010,
    TM_HF_MASTER = 3'b011,
    TM_HV_SLAVE = 3'b100,
    TM_HV_MASTER = 3'b101,
    TM_HB_SLAVE = 3'b110,
    TM_HB_MASTER = 3'b111
  } vet_tmode_t;
  typedef enum logic [1:0] {
    RTC_IDLE = 2'b00,
    RTC_SHIFT = 2'b01,
    RTC_LOAD = 2'b10
  } vet_rtc_t;
  typedef struct packed {
    logic [8:0] modeCtl;
    logic [2:0] tmode;
    logic [15:0] timing2;
    logic [31:0] pedOdd;
    logic [31:0] pedEven;
    logic [31:0] scFreq;
    logic [31:0] prdata;
    logic [1:0] hsS, blS, fdS, scS;
    logic hsP, fdP, scP;
    logic [7:0] loA, loB, hiA, hiB;
    logic [23:0] hist;
    logic [10:0] pixCnt;
    logic [9:0] lineCnt;
    logic field, vBit;
    logic [2:0] fieldSeq;
    logic scPend, scPhaseReset;
    vet_rtc_t rtcState;
    logic rtcHalf;
    logic [6:0] rtcBit;
    logic [21:0] rtcShift, rtcVal;
    logic rtcNew;
    logic [31:0] scFreqOut;
    logic [1:0] phase;
    logic [7:0] luma, cb, cr;
    logic pixValid, syncOut, blankOut, burstOut, pedOut, chromaOut;
    logic hsOut, blOut, fdOut;
  } vet_state_t;
endpackage

// ==== vet_timing_input.sv ====
// Pixel input and video timing front end of a digital video encoder.
//
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "vet_defines.svh"

module vet_timing_input (
  // Clock, reset and freeze.
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // APB register port.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pixel pins.
  input wire logic [7:0] pixelLowLane,
  input wire logic [7:0] pixelHighLane,
  // Timing pins, each split into input, output and enable, except the subcarrier sync pin, which is input only.
  input wire logic hsyncIn,
  output logic hsyncOut,
  output logic hsyncOe,
  input wire logic blankIn,
  output logic blankOut,
  output logic blankOe,
  input wire logic fieldIn,
  output logic fieldOut,
  output logic fieldOe,
  input wire logic subcarrierSyncPin,
  // Captured pixels.
  output logic [7:0] lumaOut,
  output logic [7:0] cbOut,
  output logic [7:0] crOut,
  output logic pixValid,
  // Waveform controls towards the encoder core.
  output logic syncLevel,
  output logic blankLevel,
  output logic burstGate,
  output logic pedestalOn,
  output logic chromaOn,
  output logic scPhaseReset,
  output logic [31:0] scFreqOut,
  output logic oddField
);
  import vet_pkg::*;

  vet_state_t st_reg;
  vet_state_t st_next;
  vet_tmode_t tm;
  logic [10:0] lineLen, halfLen, hsw, hsOff;
  logic [9:0] fldLen;
  logic lineEnd, fieldStart, master, hbl, vbl, eqLine, serLine;
  logic vbiLine, blankInUsed, vertBlank, hsGate, rtcMode, scRise;
  logic wide, apbWr, apbSetup;
  logic [31:0] pedBits;

  function automatic logic inWin(input logic [10:0] p, input logic [10:0] lo, input logic [10:0] hi);
    inWin = (p >= lo) && (p < hi);
  endfunction

  function automatic logic regHit(input logic [11:0] a);
    regHit = (a[1:0] == 2'b00) && (a <= `VET_OFF_RTC_FREQ);
  endfunction

  always_comb begin
    st_next = st_reg;
    tm = vet_tmode_t'(st_reg.tmode);
    master = st_reg.tmode[0];
    wide = st_reg.modeCtl[`VET_WIDE_INPUT_BIT];
    rtcMode = st_reg.modeCtl[`VET_SUBCARRIER_MODE_LOW_BIT] && st_reg.modeCtl[`VET_SUBCARRIER_MODE_HIGH_BIT];
    scRise = !st_reg.scP && st_reg.scS[1];
    apbSetup = psel && !penable;
    apbWr = psel && penable && pwrite;
    st_next.scPhaseReset = 1'b0;
    st_next.pixValid = 1'b0;
    // Pin synchronisers; the pixel lanes get the same two stages.
    st_next.hsS = {st_reg.hsS[0], hsyncIn};
    st_next.blS = {st_reg.blS[0], blankIn};
    st_next.fdS = {st_reg.fdS[0], fieldIn};
    st_next.scS = {st_reg.scS[0], subcarrierSyncPin};
    st_next.hsP = st_reg.hsS[1];
    st_next.fdP = st_reg.fdS[1];
    st_next.scP = st_reg.scS[1];
    st_next.loA = pixelLowLane;
    st_next.loB = st_reg.loA;
    st_next.hiA = pixelHighLane;
    st_next.hiB = st_reg.hiA;
    st_next.hist = {st_reg.hist[15:0], st_reg.loB};

    // Register reads are latched in the setup phase.
    if (apbSetup) begin
      case (paddr)
        `VET_OFF_MODE_SECOND: st_next.prdata = {23'h0, st_reg.modeCtl};
        `VET_OFF_TIMING_CONTROL_FIRST: st_next.prdata = {29'h0, st_reg.tmode};
        `VET_OFF_TIMING_SECOND: st_next.prdata = {16'h0, st_reg.timing2};
        `VET_OFF_PED_ODD: st_next.prdata = st_reg.pedOdd;
        `VET_OFF_PED_EVEN: st_next.prdata = st_reg.pedEven;
        `VET_OFF_SC_FREQ: st_next.prdata = st_reg.scFreq;
        `VET_OFF_STATUS: st_next.prdata = {7'h0, st_reg.field, st_reg.fieldSeq, st_reg.lineCnt, st_reg.pixCnt};
        `VET_OFF_RTC_FREQ: st_next.prdata = {10'h0, st_reg.rtcVal};
        default: st_next.prdata = 32'h0000_0000;
      endcase
    end
    if (apbWr) begin
      case (paddr)
        `VET_OFF_MODE_SECOND: st_next.modeCtl = pwdata[8:0];
        `VET_OFF_TIMING_CONTROL_FIRST: st_next.tmode = pwdata[2:0];
        `VET_OFF_TIMING_SECOND: st_next.timing2 = pwdata[15:0];
        `VET_OFF_PED_ODD: st_next.pedOdd = pwdata;
        `VET_OFF_PED_EVEN: st_next.pedEven = pwdata;
        `VET_OFF_SC_FREQ: st_next.scFreq = pwdata;
        default: st_next.modeCtl = st_reg.modeCtl;
      endcase
    end

    if (st_reg.modeCtl[`VET_SQUARE_BIT] && !master) begin
      lineLen = st_reg.modeCtl[`VET_PAL_BIT] ? `VET_PAL_SQ_LINE : `VET_NTSC_SQ_LINE;
    end else begin
      lineLen = st_reg.modeCtl[`VET_PAL_BIT] ? `VET_PAL_LINE : `VET_NTSC_LINE;
    end
    fldLen = st_reg.modeCtl[`VET_PAL_BIT] ? `VET_PAL_FIELD : `VET_NTSC_FIELD;
    halfLen = {1'b0, lineLen[10:1]};
    hsw = {3'h0, st_reg.timing2[7:0]};
    hsOff = {3'h0, st_reg.timing2[15:8]};

    // Free-running line and field counters; slaves realign them.
    lineEnd = st_reg.pixCnt == lineLen - 11'd1;
    fieldStart = 1'b0;
    st_next.pixCnt = lineEnd ? 11'd0 : st_reg.pixCnt + 11'd1;
    if (lineEnd) begin
      if (st_reg.lineCnt == fldLen - 10'd1) begin
        st_next.lineCnt = 10'd0;
        if (master) begin
          st_next.field = !st_reg.field;
          fieldStart = 1'b1;
        end
      end else begin
        st_next.lineCnt = st_reg.lineCnt + 10'd1;
      end
    end
    case (tm)
      TM_EMB_SLAVE: begin
        if (st_reg.hist == 24'hff_0000) begin
          st_next.vBit = st_reg.loB[5];
          if (st_reg.loB[4]) begin
            st_next.pixCnt = 11'd0;
            if (st_reg.loB[6] != st_reg.field) begin
              st_next.field = st_reg.loB[6];
              st_next.lineCnt = 10'd0;
              fieldStart = 1'b1;
            end
          end else begin
            st_next.pixCnt = `VET_ACT_START;
          end
        end
      end
      TM_HF_SLAVE, TM_HB_SLAVE: begin
        if (st_reg.hsP && !st_reg.hsS[1]) begin
          st_next.pixCnt = 11'd0;
        end
        if ((st_reg.fdS[1] != st_reg.fdP) && (st_reg.hsS[1] == st_reg.tmode[2])) begin
          st_next.field = st_reg.fdS[1];
          st_next.lineCnt = 10'd0;
          fieldStart = 1'b1;
        end
      end
      TM_HV_SLAVE: begin
        if (st_reg.hsP && !st_reg.hsS[1]) begin
          st_next.pixCnt = 11'd0;
        end
        if (st_reg.fdP && !st_reg.fdS[1]) begin
          st_next.field = st_reg.hsS[1];
          st_next.lineCnt = 10'd0;
          fieldStart = 1'b1;
        end
      end
      default: st_next.vBit = st_reg.lineCnt < `VET_VBL_END;
    endcase

    hbl = st_reg.pixCnt < `VET_ACT_START;
    vbl = (tm == TM_EMB_SLAVE) ? st_reg.vBit : (st_reg.lineCnt < `VET_VBL_END);
    eqLine = st_reg.lineCnt < `VET_EQ_END;
    serLine = (st_reg.lineCnt >= `VET_SER_START) && (st_reg.lineCnt < `VET_SER_END);
    if (serLine) begin
      st_next.syncOut = !(inWin(st_reg.pixCnt, halfLen - hsw, halfLen) || inWin(st_reg.pixCnt, lineLen - hsw, lineLen));
    end else if (eqLine) begin
      st_next.syncOut = inWin(st_reg.pixCnt, 11'd0, hsw >> 1) || inWin(st_reg.pixCnt, halfLen, halfLen + (hsw >> 1));
    end else begin
      st_next.syncOut = inWin(st_reg.pixCnt, 11'd0, hsw);
    end
    blankInUsed = st_reg.modeCtl[`VET_BLANK_IN_EN_BIT] && !master && (tm != TM_EMB_SLAVE);
    vbiLine = vbl && !eqLine;
    vertBlank = vbl && (eqLine || !st_reg.modeCtl[`VET_VBI_OPEN_BIT]);
    st_next.blankOut = hbl || (blankInUsed ? !st_reg.blS[1] : vertBlank);
    st_next.burstOut = st_reg.modeCtl[`VET_BURST_ENABLE_BIT] && !vbl && !eqLine
      && inWin(st_reg.pixCnt, `VET_BURST_START, `VET_BURST_END);
    st_next.chromaOut = st_reg.modeCtl[`VET_COLOR_ENABLE_BIT] && !st_next.blankOut;
    pedBits = st_reg.field ? st_reg.pedEven : st_reg.pedOdd;
    st_next.pedOut = (st_reg.lineCnt < `VET_PED_LINES) ? pedBits[st_reg.lineCnt[4:0]] : 1'b1;

    // Master pin values; slaves park them high behind a low enable.
    hsGate = inWin(st_reg.pixCnt, hsOff, hsOff + hsw);
    case (tm)
      TM_EMB_MASTER: begin
        st_next.hsOut = hbl;
        st_next.blOut = vbl;
        st_next.fdOut = st_reg.field;
      end
      TM_HF_MASTER, TM_HB_MASTER: begin
        st_next.hsOut = !hsGate;
        st_next.blOut = !st_next.blankOut;
        st_next.fdOut = st_reg.field;
      end
      TM_HV_MASTER: begin
        st_next.hsOut = !hsGate;
        st_next.blOut = !st_next.blankOut;
        st_next.fdOut = !serLine;
      end
      default: begin
        st_next.hsOut = 1'b1;
        st_next.blOut = 1'b1;
        st_next.fdOut = 1'b1;
      end
    endcase

    if (hbl) begin
      st_next.phase = 2'b00;
    end else if (wide) begin
      st_next.phase[0] = !st_reg.phase[0];
      if (!st_reg.phase[0]) begin
        st_next.luma = st_reg.loB;
        st_next.pixValid = 1'b1;
        st_next.phase[1] = !st_reg.phase[1];
        if (st_reg.phase[1]) begin
          st_next.cr = st_reg.hiB;
        end else begin
          st_next.cb = st_reg.hiB;
        end
      end
    end else begin
      // Byte order Cb Y Cr Y
      st_next.phase = st_reg.phase + 2'b01;
      case (st_reg.phase)
        2'b00: st_next.cb = st_reg.loB;
        2'b10: st_next.cr = st_reg.loB;
        default: begin
          st_next.luma = st_reg.loB;
          st_next.pixValid = 1'b1;
        end
      endcase
    end

    if (fieldStart) begin
      st_next.scPhaseReset = st_reg.scPend;
      st_next.fieldSeq = st_reg.scPend ? 3'h0 : st_reg.fieldSeq + 3'h1;
      st_next.scPend = 1'b0;
    end
    if (st_reg.modeCtl[`VET_SUBCARRIER_MODE_LOW_BIT] && !st_reg.modeCtl[`VET_SUBCARRIER_MODE_HIGH_BIT] && scRise) begin
      st_next.scPend = 1'b1;
    end

    case (st_reg.rtcState)
      RTC_IDLE: begin
        if (rtcMode && scRise) begin
          st_next.rtcState = RTC_SHIFT;
          st_next.rtcBit = 7'h0;
          st_next.rtcHalf = 1'b0;
        end
      end
      RTC_SHIFT: begin
        st_next.rtcHalf = !st_reg.rtcHalf;
        if (st_reg.rtcHalf) begin
          st_next.rtcBit = st_reg.rtcBit + 7'h1;
          if (st_reg.rtcBit < `VET_RTC_FREQ_BITS) begin
            st_next.rtcShift = {st_reg.scS[1], st_reg.rtcShift[21:1]};
          end
          if (st_reg.rtcBit == `VET_RTC_WORD - 7'h1) begin
            st_next.rtcState = RTC_LOAD;
          end
        end
      end
      RTC_LOAD: begin
        st_next.rtcVal = st_reg.rtcShift;
        st_next.rtcState = RTC_IDLE;
      end
      default: st_next.rtcState = RTC_IDLE;
    endcase
    if (!rtcMode) begin
      st_next.scFreqOut = st_reg.scFreq;
    end else if (lineEnd && st_reg.rtcNew) begin
      st_next.scFreqOut = st_reg.scFreq + {10'h0, st_reg.rtcVal};
      st_next.rtcNew = 1'b0;
    end
    // A word finishing on the consuming line end is kept, not lost.
    if (st_reg.rtcState == RTC_LOAD) begin
      st_next.rtcNew = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.modeCtl <= `VET_MODE_RST;
      st_reg.tmode <= `VET_TMODE_RST;
      st_reg.timing2 <= `VET_TIMING2_RST;
      st_reg.pedOdd <= `VET_PED_RST;
      st_reg.pedEven <= `VET_PED_RST;
      st_reg.scFreq <= `VET_SCF_RST;
      st_reg.scFreqOut <= `VET_SCF_RST;
      st_reg.hsS <= 2'b11;
      st_reg.blS <= 2'b11;
      st_reg.fdS <= 2'b11;
      st_reg.hsP <= 1'b1;
      st_reg.fdP <= 1'b1;
      st_reg.hsOut <= 1'b1;
      st_reg.blOut <= 1'b1;
      st_reg.fdOut <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign hsyncOe = st_reg.tmode[0];
  assign blankOe = st_reg.tmode[0];
  assign fieldOe = st_reg.tmode[0];
  assign hsyncOut = st_reg.hsOut;
  assign blankOut = st_reg.blOut;
  assign fieldOut = st_reg.fdOut;
  assign pready = ce;
  assign pslverr = psel && penable && !regHit(paddr);
  assign prdata = st_reg.prdata;
  assign lumaOut = st_reg.luma;
  assign cbOut = st_reg.cb;
  assign crOut = st_reg.cr;
  assign pixValid = st_reg.pixValid;
  assign syncLevel = st_reg.syncOut;
  assign blankLevel = st_reg.blankOut;
  assign burstGate = st_reg.burstOut;
  assign pedestalOn = st_reg.pedOut;
  assign chromaOn = st_reg.chromaOut;
  assign scPhaseReset = st_reg.scPhaseReset;
  assign scFreqOut = st_reg.scFreqOut;
  assign oddField = !st_reg.field;

  default clocking cb_main @(posedge clk);
  endclocking
  default disable iff (!rstn || !ce);

  property p_color;
    st_reg.chromaOut |-> $past(st_reg.modeCtl[`VET_COLOR_ENABLE_BIT]) && !st_reg.blankOut;
  endproperty
  a_color: assert property (p_color) else $error("colour on while disabled or blanked");

  property p_burst;
    st_reg.burstOut |-> $past(st_reg.modeCtl[`VET_BURST_ENABLE_BIT]) && ($past(st_reg.pixCnt) >= `VET_BURST_START);
  endproperty
  a_burst: assert property (p_burst) else $error("burst gate outside its window");

  property p_byte;
    $past(!wide) && st_reg.pixValid |-> st_reg.luma == $past(st_reg.loB) && $past(st_reg.phase[0]);
  endproperty
  a_byte: assert property (p_byte) else $error("luma byte taken at wrong phase");

  sequence s_wide_load;
    $past(wide) && wide && st_reg.pixValid;
  endsequence
  property p_wide;
    s_wide_load |=> !st_reg.pixValid;
  endproperty
  a_wide: assert property (p_wide) else $error("wide word loaded on adjacent edges");

  property p_screset;
    st_reg.scPhaseReset |-> $past(st_reg.scPend) && (st_reg.fieldSeq == 3'h0);
  endproperty
  a_screset: assert property (p_screset) else $error("phase reset without pending request");

  property p_rtcupd;
    rtcMode && lineEnd && st_reg.rtcNew |=> st_reg.scFreqOut == $past(st_reg.scFreq) + {10'h0, $past(st_reg.rtcVal)};
  endproperty
  a_rtcupd: assert property (p_rtcupd) else $error("line update missed lock value");

  sequence s_rtc_start;
    st_reg.rtcState == RTC_IDLE ##1 st_reg.rtcState == RTC_SHIFT;
  endsequence
  property p_rtclen;
    s_rtc_start |-> ##133 st_reg.rtcState == RTC_SHIFT ##1 st_reg.rtcState == RTC_LOAD;
  endproperty
  a_rtclen: assert property (p_rtclen) else $error("serial word not 134 cycles");

  property p_vbi;
    $past(vbiLine && !hbl && !blankInUsed) |-> st_reg.blankOut == !$past(st_reg.modeCtl[`VET_VBI_OPEN_BIT]);
  endproperty
  a_vbi: assert property (p_vbi) else $error("open VBI line blanking wrong");

  property p_embm;
    (st_reg.tmode == TM_EMB_MASTER) && $past(st_reg.tmode == TM_EMB_MASTER)
      |-> hsyncOe && (hsyncOut == ($past(st_reg.pixCnt) < `VET_ACT_START));
  endproperty
  a_embm: assert property (p_embm) else $error("H bit not driven on sync pin");
endmodule

// ==== vet_timing_input_bench.sv ====
// Self-checking bench for the video timing front end.
`timescale 1ns/100ps
module vet_timing_input_bench;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, scFreqOut, rd;
  logic pready, pslverr, err, hsyncOut, hsyncOe, blankOut, blankOe, fieldOut, fieldOe, pinLevel, scPin;
  logic [7:0] pixLow, pixHigh, lumaOut, cbOut, crOut;
  logic pixValid, syncLevel, blankLevel, burstGate, pedestalOn, chromaOn, scPhaseReset, oddField, oldOdd;
  logic wide = 1'h0;
  logic fBit = 1'h0;
  logic [31:0] rstVals [6] = '{32'h3, 32'h0, 32'h40, 32'h0, 32'h0, 32'h0};
  int badCount = 0;
  int nCompared = 0;
  int nChroma, nBurst, nPix, nAlt, nReset, nSync, nPed;
  always #2 clk = ~clk;
  vet_video_source src (.clk(clk), .wide(wide), .fBit(fBit), .pixLow(pixLow), .pixHigh(pixHigh),
    .pinLevel(pinLevel), .scPin(scPin));
  vet_timing_input dut (.clk(clk), .rstn(rstn), .ce(1'h1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pixelLowLane(pixLow), .pixelHighLane(pixHigh), .hsyncIn(hsyncOe ? hsyncOut : pinLevel),
    .hsyncOut(hsyncOut), .hsyncOe(hsyncOe), .blankIn(blankOe ? blankOut : pinLevel), .blankOut(blankOut),
    .blankOe(blankOe), .fieldIn(fieldOe ? fieldOut : pinLevel), .fieldOut(fieldOut), .fieldOe(fieldOe),
    .subcarrierSyncPin(scPin), .lumaOut(lumaOut), .cbOut(cbOut), .crOut(crOut), .pixValid(pixValid),
    .syncLevel(syncLevel), .blankLevel(blankLevel), .burstGate(burstGate), .pedestalOn(pedestalOn),
    .chromaOn(chromaOn), .scPhaseReset(scPhaseReset), .scFreqOut(scFreqOut), .oddField(oddField));
  task automatic tally_and_finish;
    $display("counts: %0d compared, %0d unexpected", nCompared, badCount);
    if (badCount == 0 && nCompared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic expect32(input logic [31:0] got, input logic [31:0] want, input string what);
    nCompared++;
    if (got !== want) begin
      badCount++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) begin
      badCount++;
      tally_and_finish();
    end
  endtask
  // Watches the outputs for a number of cycles, counting the cycles each control but blankLevel and oddField is high and checking byte pairing.
  task automatic watch(input int cycles);
    int bad;
    bad = 0;
    nChroma = 0;
    nBurst = 0;
    nPix = 0;
    nAlt = 0;
    nReset = 0;
    nSync = 0;
    nPed = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      nSync += (syncLevel === 1'h1);
      nPed += (pedestalOn !== 1'h0);
      nChroma += (chromaOn === 1'h1);
      nBurst += (burstGate === 1'h1);
      nReset += (scPhaseReset === 1'h1);
      if (pixValid === 1'h1) begin
        if (lumaOut === 8'h22 && cbOut === 8'h11)
          nPix++;
        else if (lumaOut === 8'h44 && crOut === 8'h33)
          nAlt++;
        else
          bad++;
      end
    end
    expect32(32'(bad), 32'h0, "pixel pairing");
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'h1;
    for (int k = 0; k < 6; k++) begin
      apb(1'h0, 12'(4 * k), 32'h0);
      expect32(rd, rstVals[k], "reset value");
    end
    apb(1'h0, 12'h020, 32'h0);
    expect32({err, rd[30:0]}, 32'h8000_0000, "unmapped read");
    for (int t = 0; t < 8; t++) begin
      apb(1'h1, 12'h004, 32'(t));
      apb(1'h0, 12'h004, 32'h0);
      expect32(rd, 32'(t), "timing mode");
      expect32({29'h0, hsyncOe, blankOe, fieldOe}, {29'h0, {3{t[0]}}}, "pin drive");
    end
    apb(1'h1, 12'h004, 32'h0);
    $display("test registers done");
    // Let the line counter leave vertical blanking before judging burst and colour.
    repeat (36036) @(posedge clk);
    watch(1716);
    expect32({30'h0, nPix > 0, nAlt > 0}, 32'h3, "byte order");
    expect32({30'h0, nChroma > 0, nBurst > 0}, 32'h3, "colour and burst on");
    // Early lines of the field read pedestal bits that reset left at zero.
    expect32({30'h0, nSync > 0, nPed == 0}, 32'h3, "sync and early pedestal");
    apb(1'h1, 12'h000, 32'h0);
    repeat (1716) @(posedge clk);
    watch(1716);
    expect32(32'(nChroma + nBurst), 32'h0, "colour and burst off");
    $display("test pixels and controls done");
    apb(1'h1, 12'h014, 32'h0);
    apb(1'h1, 12'h000, 32'h00f);
    src.sendLock({{15{3'h5}}, 22'h2a5c3});
    repeat (3432) @(posedge clk);
    expect32(scFreqOut, 32'h0002_a5c3, "lock frequency");
    apb(1'h0, 12'h01c, 32'h0);
    expect32(rd, 32'h0002_a5c3, "lock readback");
    $display("test lock done");
    apb(1'h1, 12'h000, 32'h023);
    wide <= 1'h1;
    repeat (1716) @(posedge clk);
    watch(1716);
    expect32({30'h0, nPix > 0, nAlt > 0}, 32'h3, "wide words");
    $display("test wide done");
    apb(1'h1, 12'h000, 32'h007);
    wide <= 1'h0;
    repeat (1716) @(posedge clk);
    src.pulseReset();
    watch(1716);
    expect32(32'(nReset), 32'h0, "early phase reset");
    oldOdd = oddField;
    fBit <= ~fBit;
    watch(3432);
    expect32(32'(nReset), 32'h1, "phase reset at field");
    expect32({31'h0, oddField !== oldOdd}, 32'h1, "field toggle");
    $display("test phase reset done");
    tally_and_finish();
  end
endmodule

// ==== vet_video_source.sv ====
// Behavioural video decoder: pixels, embedded codes, idle sync pins and the lock pin.
`timescale 1ns/100ps
module vet_video_source (
  // Clock and bench controls.
  input wire logic clk,
  input wire logic wide,
  input wire logic fBit,
  // Pins towards the encoder.
  output logic [7:0] pixLow,
  output logic [7:0] pixHigh,
  output logic pinLevel,
  output logic scPin
);
  logic fLine = 1'h0;
  int a;
  assign pinLevel = 1'h1;
  initial begin
    pixLow = 8'h80;
    pixHigh = 8'h00;
    scPin = 1'h0;
  end
  // codes before and after each line, then Cb Y Cr Y
  always begin
    for (int i = 0; i < 1716; i++) begin
      @(posedge clk);
      a = i - 272;
      if (i == 0)
        fLine <= fBit;
      // The unused high lane toggles so that a stale value is never mistaken for data.
      pixHigh <= (wide && a >= 0) ? (a[1] ? 8'h33 : 8'h11) : ~pixHigh;
      if (i < 4 || (i >= 268 && a < 0))
        pixLow <= (i % 4 == 0) ? 8'hff : (i % 4 != 3) ? 8'h00 :
                  (i < 4) ? (fLine ? 8'hda : 8'h9d) : (fLine ? 8'hc7 : 8'h80);
      else if (a < 0)
        pixLow <= i[0] ? 8'h10 : 8'h80;
      else if (wide)
        pixLow <= a[1] ? 8'h44 : 8'h22;
      else
        pixLow <= (a % 4 == 0) ? 8'h11 : (a % 4 == 1) ? 8'h22 : (a % 4 == 2) ? 8'h33 : 8'h44;
    end
  end
  // start rise, then 67 bits of two clocks each, least significant first
  task automatic sendLock(input logic [66:0] w);
    @(posedge clk);
    scPin <= 1'h1;
    @(posedge clk);
    for (int k = 0; k < 67; k++) begin
      @(posedge clk);
      scPin <= w[k];
      @(posedge clk);
    end
    @(posedge clk);
    scPin <= 1'h0;
  endtask
  // a rising transition arms the phase reset
  task automatic pulseReset;
    @(posedge clk);
    scPin <= 1'h1;
    repeat (4) @(posedge clk);
    scPin <= 1'h0;
  endtask
endmodule
